// *** shared/blf_pkg.sv ***
// Package of constants and types for the basic logic function unit
package blf_pkg;
    localparam int unsigned N_IN      = 4;      // Inputs per AND, NAND, OR and NOR block
    localparam int unsigned N_XOR     = 2;      // Inputs of the exclusive-or block
    localparam logic [3:0]  CONN_RST  = 4'h0;   // Reset value: nothing connected
    localparam logic [3:0]  INV_RST   = 4'h0;   // Reset value: no input inverted
    localparam logic [3:0]  HIST_RST  = 4'hf;   // Reset history: all high
    localparam logic        OUT_RST   = 1'h0;   // Reset value of every output
    typedef logic [N_IN-1:0] blf_vec_t;
endpackage

// *** shared/blf_hist_if.sv ***
// Interface carrying the previous-cycle input history between modules
`timescale 1ns/1ps
interface blf_hist_if;
    logic                 cyc;      // Program cycle strobe
    blf_pkg::blf_vec_t    and_cur;  // Current effective inputs of edge AND
    blf_pkg::blf_vec_t    nand_cur; // Current effective inputs of edge NAND
    blf_pkg::blf_vec_t    and_prev; // Stored inputs from the last cycle
    blf_pkg::blf_vec_t    nand_prev;
    modport store (input cyc, input and_cur, input nand_cur, output and_prev, output nand_prev);
    modport user  (output cyc, output and_cur, output nand_cur, input and_prev, input nand_prev);
endinterface

// *** rtl/blf_hist.sv ***
// Storage of the previous program cycle inputs for the edge blocks
`timescale 1ns/1ps
module blf_hist (
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    blf_hist_if.store hist
);
    blf_pkg::blf_vec_t and_q;
    blf_pkg::blf_vec_t and_d;
    blf_pkg::blf_vec_t nand_q;
    blf_pkg::blf_vec_t nand_d;

    // Capture only on the strobe so history spans whole program cycles
    always_comb begin
        and_d  = hist.cyc ? hist.and_cur : and_q;
        nand_d = hist.cyc ? hist.nand_cur : nand_q;
    end

    // History set to all high at reset: no edge is seen until a low appears
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            and_q  <= blf_pkg::HIST_RST;
            nand_q <= blf_pkg::HIST_RST;
        end else begin
            and_q  <= and_d;
            nand_q <= nand_d;
        end
    end

    assign hist.and_prev  = and_q;
    assign hist.nand_prev = nand_q;
endmodule

// *** rtl/blf_unit.sv ***
// Basic Boolean function blocks evaluated once per program cycle
`timescale 1ns/1ps
module blf_unit (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    input  wire logic       cyc_i,        // One-clock program cycle strobe
    input  wire logic [3:0] and_in_i,
    input  wire logic [3:0] and_conn_i,   // High where an input is connected
    input  wire logic [3:0] and_inv_i,    // High where an input is inverted
    input  wire logic [3:0] andr_in_i,
    input  wire logic [3:0] andr_conn_i,
    input  wire logic [3:0] andr_inv_i,
    input  wire logic [3:0] nand_in_i,
    input  wire logic [3:0] nand_conn_i,
    input  wire logic [3:0] nand_inv_i,
    input  wire logic [3:0] nandr_in_i,
    input  wire logic [3:0] nandr_conn_i,
    input  wire logic [3:0] nandr_inv_i,
    input  wire logic [3:0] or_in_i,
    input  wire logic [3:0] or_conn_i,
    input  wire logic [3:0] or_inv_i,
    input  wire logic [3:0] nor_in_i,
    input  wire logic [3:0] nor_conn_i,
    input  wire logic [3:0] nor_inv_i,
    input  wire logic [1:0] xor_in_i,
    input  wire logic [1:0] xor_conn_i,
    input  wire logic [1:0] xor_inv_i,
    input  wire logic       not_in_i,
    input  wire logic       not_inv_i,
    output logic            and_o,
    output logic            andr_o,
    output logic            nand_o,
    output logic            nandr_o,
    output logic            or_o,
    output logic            nor_o,
    output logic            xor_o,
    output logic            not_o
);
    blf_hist_if hist ();
    blf_pkg::blf_vec_t e_and;
    blf_pkg::blf_vec_t e_andr;
    blf_pkg::blf_vec_t e_nand;
    blf_pkg::blf_vec_t e_nandr;
    blf_pkg::blf_vec_t e_or;
    blf_pkg::blf_vec_t e_nor;
    logic [1:0]        e_xor;
    logic              e_not;
    // Registered outputs and their next values
    logic              and_q;
    logic              andr_q;
    logic              nand_q;
    logic              nandr_q;
    logic              or_q;
    logic              nor_q;
    logic              xor_q;
    logic              not_q;
    logic              and_d;
    logic              andr_d;
    logic              nand_d;
    logic              nandr_d;
    logic              or_d;
    logic              nor_d;
    logic              xor_d;
    logic              not_d;

    // Per input: invert first, then substitute the idle level when unconnected
    // Inversion on an open input has no effect, since the idle level replaces it
    genvar g;
    generate
        for (g = 0; g < blf_pkg::N_IN; g++) begin : g_in
            assign e_and[g]   = and_conn_i[g]   ? (and_in_i[g] ^ and_inv_i[g])     : 1'h1;
            assign e_andr[g]  = andr_conn_i[g]  ? (andr_in_i[g] ^ andr_inv_i[g])   : 1'h1;
            assign e_nand[g]  = nand_conn_i[g]  ? (nand_in_i[g] ^ nand_inv_i[g])   : 1'h1;
            assign e_nandr[g] = nandr_conn_i[g] ? (nandr_in_i[g] ^ nandr_inv_i[g]) : 1'h1;
            assign e_or[g]    = or_conn_i[g]    ? (or_in_i[g] ^ or_inv_i[g])       : 1'h0;
            assign e_nor[g]   = nor_conn_i[g]   ? (nor_in_i[g] ^ nor_inv_i[g])     : 1'h0;
        end
        // The exclusive-or shares the low idle level of OR and NOR
        for (g = 0; g < blf_pkg::N_XOR; g++) begin : g_xor
            assign e_xor[g] = xor_conn_i[g] ? (xor_in_i[g] ^ xor_inv_i[g]) : 1'h0;
        end
    endgenerate
    assign e_not = not_in_i ^ not_inv_i;

    // History of the edge blocks lives in its own module
    // Kept apart so the per-cycle state is reset and checked on its own
    assign hist.cyc      = cyc_i;
    assign hist.and_cur  = e_andr;
    assign hist.nand_cur = e_nandr;
    blf_hist u_hist (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .hist      (hist.store)
    );

    // Next outputs; held between strobes so every block changes once per cycle
    always_comb begin
        and_d   = and_q;
        andr_d  = andr_q;
        nand_d  = nand_q;
        nandr_d = nandr_q;
        or_d    = or_q;
        nor_d   = nor_q;
        xor_d   = xor_q;
        not_d   = not_q;
        // An edge pulse lasts one program cycle, not one clock
        if (cyc_i) begin
            and_d   = &e_and;
            // Edge needs a low last cycle, so a pulse can never repeat back to back
            andr_d  = (&e_andr) & ~(&hist.and_prev);
            nand_d  = ~(&e_nand);
            nandr_d = ~(&e_nandr) & (&hist.nand_prev);
            or_d    = |e_or;
            nor_d   = ~(|e_nor);
            xor_d   = e_xor[0] ^ e_xor[1];
            not_d   = ~e_not;
        end
    end

    // Output registers; reset drives all low
    // NAND, NOR and NOT therefore read low until the first strobe
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            and_q   <= blf_pkg::OUT_RST;
            andr_q  <= blf_pkg::OUT_RST;
            nand_q  <= blf_pkg::OUT_RST;
            nandr_q <= blf_pkg::OUT_RST;
            or_q    <= blf_pkg::OUT_RST;
            nor_q   <= blf_pkg::OUT_RST;
            xor_q   <= blf_pkg::OUT_RST;
            not_q   <= blf_pkg::OUT_RST;
        end else begin
            and_q   <= and_d;
            andr_q  <= andr_d;
            nand_q  <= nand_d;
            nandr_q <= nandr_d;
            or_q    <= or_d;
            nor_q   <= nor_d;
            xor_q   <= xor_d;
            not_q   <= not_d;
        end
    end

    // Outputs come straight from the registers
    assign and_o   = and_q;
    assign andr_o  = andr_q;
    assign nand_o  = nand_q;
    assign nandr_o = nandr_q;
    assign or_o    = or_q;
    assign nor_o   = nor_q;
    assign xor_o   = xor_q;
    assign not_o   = not_q;

    // Checks tie each output to its inputs on the strobe that produced it
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // Checks are off in reset; the first strobe after release is judged in full

    edge_and_rise_a: assert property (cyc_i |=> andr_o == ((&$past(e_andr)) & ~(&$past(hist.and_prev))))
        else $error("edge AND output wrong");
    edge_and_gap_a: assert property (andr_o && cyc_i |=> !andr_o)
        else $error("edge AND held more than one cycle");
    edge_nand_gap_a: assert property (nandr_o && cyc_i |=> !nandr_o)
        else $error("edge NAND held more than one cycle");
    and_float_a: assert property (cyc_i && and_conn_i == 4'h0 |=> and_o)
        else $error("unconnected AND inputs not high");
    nand_value_a: assert property (cyc_i |=> nand_o == !(&$past(e_nand)))
        else $error("NAND output wrong");
    or_value_a: assert property (cyc_i |=> or_o == (|$past(e_or)))
        else $error("OR output wrong");
    nor_value_a: assert property (cyc_i |=> nor_o == !(|$past(e_nor)))
        else $error("NOR output wrong");
    or_float_a: assert property (cyc_i && or_conn_i == 4'h0 && nor_conn_i == 4'h0 |=> !or_o && nor_o)
        else $error("unconnected OR or NOR inputs not low");
    xor_value_a: assert property (cyc_i |=> xor_o == ($past(e_xor[0]) ^ $past(e_xor[1])))
        else $error("XOR output wrong");
    not_value_a: assert property (cyc_i |=> not_o == !$past(e_not))
        else $error("NOT output wrong");
    and_value_a: assert property (cyc_i |=> and_o == (&$past(e_and)))
        else $error("AND output wrong");
    edge_nand_rise_a: assert property (cyc_i |=> nandr_o == (!(&$past(e_nandr)) & (&$past(hist.nand_prev))))
        else $error("edge NAND output wrong");
    hold_between_a: assert property (!cyc_i |=> $stable(andr_o) && $stable(nandr_o) && $stable(or_o)
        && $stable(and_o) && $stable(nand_o) && $stable(nor_o) && $stable(xor_o) && $stable(not_o))
        else $error("output moved without cycle strobe");

    // Idle levels of open inputs and the complement pairs
    nand_float_a: assert property (cyc_i && nand_conn_i == 4'h0 |=> !nand_o)
        else $error("unconnected NAND inputs not high");
    edge_nand_float_a: assert property (cyc_i && nandr_conn_i == 4'h0 |=> !nandr_o)
        else $error("unconnected edge NAND inputs not high");
    xor_float_a: assert property (cyc_i && xor_conn_i == 2'h0 |=> !xor_o)
        else $error("unconnected XOR inputs not low");
    nand_pair_a: assert property (cyc_i && nand_in_i == and_in_i && nand_conn_i == and_conn_i
        && nand_inv_i == and_inv_i |=> nand_o != and_o)
        else $error("NAND not the complement of AND");
    nor_pair_a: assert property (cyc_i && nor_in_i == or_in_i && nor_conn_i == or_conn_i
        && nor_inv_i == or_inv_i |=> nor_o != or_o)
        else $error("NOR not the complement of OR");

    // History moves only on a strobe and takes the effective inputs
    hist_capture_a: assert property (cyc_i |=> hist.and_prev == $past(e_andr)
        && hist.nand_prev == $past(e_nandr))
        else $error("edge history not captured on strobe");
    hist_hold_a: assert property (!cyc_i |=> $stable(hist.and_prev) && $stable(hist.nand_prev))
        else $error("edge history moved without strobe");

    // Main scenarios
    edge_and_pulse_c: cover property (cyc_i ##1 $rose(andr_o));
    edge_nand_pulse_c: cover property (cyc_i ##1 $rose(nandr_o));
    xor_high_c: cover property (cyc_i ##1 xor_o);
    inverted_not_c: cover property (cyc_i && not_inv_i ##1 not_o == not_in_i);
    nor_high_c: cover property (cyc_i ##1 nor_o);
endmodule

// *** sim/blf_unit_test.sv ***
// Self-checking testbench for the basic logic function unit
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module blf_unit_test;
    logic       clk_sys_i, rst_i, cyc;
    logic [3:0] bi[6], bc[6], bv[6]; // 0 and, 1 edge and, 2 nand, 3 edge nand, 4 or, 5 nor
    logic [1:0] xi, xc, xv;
    logic       ni, nv;
    logic       and_o, andr_o, nand_o, nandr_o, or_o, nor_o, xor_o, not_o;
    int         n_mismatch = 0;
    int         samples_checked = 0;
    // Edge table rows: input, connected, inverted, expected {edge and, edge nand}
    localparam logic [13:0] EDGE[10] = '{{4'hf,4'hf,4'h0,2'h0}, {4'he,4'hf,4'h0,2'h1}, {4'hf,4'hf,4'h0,2'h2},
        {4'hf,4'hf,4'h0,2'h0}, {4'hc,4'hf,4'h0,2'h1}, {4'h0,4'hf,4'h0,2'h0}, {4'hf,4'hf,4'h0,2'h2},
        {4'h8,4'h7,4'h0,2'h1}, {4'h7,4'h7,4'h0,2'h2}, {4'h0,4'hf,4'hf,2'h0}};
    blf_unit i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cyc_i(cyc),
        .and_in_i(bi[0]), .and_conn_i(bc[0]), .and_inv_i(bv[0]), .andr_in_i(bi[1]), .andr_conn_i(bc[1]),
        .andr_inv_i(bv[1]), .nand_in_i(bi[2]), .nand_conn_i(bc[2]), .nand_inv_i(bv[2]), .nandr_in_i(bi[3]),
        .nandr_conn_i(bc[3]), .nandr_inv_i(bv[3]), .or_in_i(bi[4]), .or_conn_i(bc[4]), .or_inv_i(bv[4]),
        .nor_in_i(bi[5]), .nor_conn_i(bc[5]), .nor_inv_i(bv[5]), .xor_in_i(xi), .xor_conn_i(xc),
        .xor_inv_i(xv), .not_in_i(ni), .not_inv_i(nv), .and_o(and_o), .andr_o(andr_o), .nand_o(nand_o),
        .nandr_o(nandr_o), .or_o(or_o), .nor_o(nor_o), .xor_o(xor_o), .not_o(not_o));
    // Effective inputs: unconnected read high for the and family, low for the or family
    function automatic logic [3:0] hi_fill(input logic [3:0] i, input logic [3:0] c, input logic [3:0] v);
        return (i ^ v) | ~c;
    endfunction
    function automatic logic [3:0] lo_fill(input logic [3:0] i, input logic [3:0] c, input logic [3:0] v);
        return (i ^ v) & c;
    endfunction
    task automatic set_all(input logic [3:0] i, input logic [3:0] c, input logic [3:0] v);
        for (int b = 0; b < 6; b++) begin
            bi[b] = i; bc[b] = c; bv[b] = v;
        end
        xi = i[1:0]; xc = c[1:0]; xv = v[1:0]; ni = i[0]; nv = v[1];
    endtask
    // One program cycle strobe; outputs are settled when this returns
    task automatic strobe;
        @(posedge clk_sys_i); #1 cyc = 1'h1;
        @(posedge clk_sys_i); #1 cyc = 1'h0;
    endtask
    task automatic do_reset;
        @(posedge clk_sys_i); #1 rst_i = 1'h1;
        repeat (20) @(posedge clk_sys_i);
        #1 rst_i = 1'h0;
    endtask
    // Every input pattern of the plain blocks, with and without inversion and open inputs
    task automatic t_comb;
        logic [3:0] c, v, e, o, x;
        for (int k = 0; k < 48; k++) begin
            c = (k < 32) ? 4'hf : (k[3:0] ^ 4'h6);
            v = k[4] ? 4'ha : 4'h0;
            set_all(k[3:0], c, v);
            strobe;
            e = hi_fill(k[3:0], c, v); o = lo_fill(k[3:0], c, v);
            x = lo_fill({2'h0, k[1:0]}, {2'h0, c[1:0]}, {2'h0, v[1:0]});
            `CHK(and_o, &e)
            `CHK(nand_o, ~&e)
            `CHK(or_o, |o)
            `CHK(nor_o, ~|o)
            `CHK(xor_o, ^x[1:0])
            `CHK(not_o, ~(k[0] ^ v[1]))
        end
    endtask
    // Edge blocks walked through rising and falling patterns from reset
    task automatic t_edge;
        do_reset;
        for (int r = 0; r < 10; r++) begin
            bi[1] = EDGE[r][13:10]; bc[1] = EDGE[r][9:6]; bv[1] = EDGE[r][5:2];
            bi[3] = EDGE[r][13:10]; bc[3] = EDGE[r][9:6]; bv[3] = EDGE[r][5:2];
            strobe;
            `CHK({andr_o, nandr_o}, EDGE[r][1:0])
        end
    endtask
    // Pulse holds between strobes and ignores input changes meanwhile
    task automatic t_hold;
        bv[1] = 4'h0; bv[3] = 4'h0;
        bi[1] = 4'h0; bi[3] = 4'hf; strobe;
        bi[1] = 4'hf; strobe;
        `CHK({andr_o, nandr_o}, 2'h2)
        bi[1] = 4'h0; bi[3] = 4'h0;
        repeat (3) @(posedge clk_sys_i);
        #1 `CHK({andr_o, nandr_o}, 2'h2)
        strobe;
        `CHK({andr_o, nandr_o}, 2'h1)
    endtask
    // Reset in mid-run clears outputs and sets the stored history back to all high
    task automatic t_rst;
        set_all(4'h3, 4'hf, 4'h0); strobe;
        do_reset;
        `CHK({and_o, andr_o, nand_o, nandr_o, or_o, nor_o, xor_o, not_o}, 8'h00)
        bi[1] = 4'hf; bi[3] = 4'hf; strobe;
        `CHK({andr_o, nandr_o}, 2'h0)
    endtask
    task automatic end_sim;
        $display("Checked %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        clk_sys_i = 1'h0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // Hang guard: the whole run needs far fewer cycles than this
    initial begin
        #100us;
        n_mismatch++;
        end_sim;
    end
    initial begin
        rst_i = 1'h1; cyc = 1'h0;
        set_all(4'h0, 4'hf, 4'h0);
        do_reset;
        t_comb;
        t_edge;
        t_hold;
        t_rst;
        end_sim;
    end
endmodule
